/* File: frsc_pkg.sv */
// Package for the fault response configuration bank
// Assumes 16-bit registers reached over a plain strobe port
package frsc_pkg;
    // Register indices (chosen word offsets)
    localparam logic [3:0] ADDR_RESP = 4'h0;
    localparam logic [3:0] ADDR_SUPPLY = 4'h1;
    localparam logic [3:0] ADDR_STATUS = 4'h2;
    // Reset values
    localparam logic [15:0] RESP_RST = 16'hc008;
    localparam logic [15:0] SUPPLY_RST = 16'h0000;
    // Fault response register field positions
    localparam int WARN_BIT = 15;
    localparam int SPARE_HI_BIT = 14;
    localparam int SC_LSB = 12;
    localparam int REG_BIT = 11;
    localparam int RSVD_BIT = 10;
    localparam int OC_LSB = 8;
    localparam int PS_LSB = 6;
    localparam int GM_LSB = 2;
    localparam int LINK_LSB = 0;
    // Supply register field positions
    localparam int PUV_LSB = 14;
    localparam int POV_LSB = 12;
    localparam int NUV_LSB = 10;
    localparam int NOV_LSB = 8;
    localparam int TRIM_LSB = 6;
    localparam int CFGC_LSB = 4;
    localparam int CLAMP_LSB = 2;
    localparam int CLK_LSB = 0;
    // Response codes
    localparam logic [1:0] RESP_LOW = 2'h0;
    localparam logic [1:0] RESP_HIGH = 2'h1;
    localparam logic [1:0] RESP_HIZ = 2'h2;
    localparam logic [1:0] RESP_NONE = 2'h3;
    // Clamp hold base time and cycles at 25 MHz
    localparam int CLK_NS = 40;
    localparam int CLAMP_STEP_NS = 100;
    localparam int CLAMP_STEP_CYC = CLAMP_STEP_NS / CLK_NS;
endpackage

/* File: frsc_bank.sv */
// Fault response configuration bank: two config registers and a status word
// Assumes a synchronous strobe master on CLK; fault inputs come from pins
`timescale 1ns/1ps
`default_nettype none
module frsc_bank
(
    // Clock and reset
    input wire logic CLK,
    input wire logic ARST_N,
    // Register port
    input wire logic [3:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [15:0] RDATA,
    // Fault inputs from the detectors (asynchronous)
    input wire logic [11:0] FAULT_IN,
    input wire logic OVERTEMP_IN,
    input wire logic CRC_CLEAR,
    // Gate outputs (pull pair and hi-z) and status
    output logic PULL_HIGH,
    output logic PULL_LOW,
    output logic GATE_HIZ,
    output logic OVERTEMP_WARN,
    output logic CONFIG_CRC_FAULT_FLAG,
    output logic CLAMP_ACTIVE
);
    logic [15:0] resp_r;
    logic [15:0] supply_r;
    logic [11:0] flt_meta_r;
    logic [11:0] flt_r;
    logic [1:0] ot_sync_r;
    logic [1:0] clr_sync_r;
    logic crc_flag_r;
    logic [15:0] rdata_r;
    logic ph_r;
    logic pl_r;
    logic hz_r;
    logic warn_r;
    logic clamp_r;
    logic clamp_prev_r;
    logic [3:0] clamp_cnt_r;
    logic [1:0] code [0:11];
    logic want_hi;
    logic want_lo;
    logic want_hz;
    logic [3:0] clamp_len;

    // Field extraction shared by both registers
    function automatic logic [1:0] fld(input logic [15:0] r, input int lsb);
        fld = r[lsb +: 2];
    endfunction

    // Register writes; spare bits just store
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            resp_r <= frsc_pkg::RESP_RST;
            supply_r <= frsc_pkg::SUPPLY_RST;
        end
        else if (WR && ADDR == frsc_pkg::ADDR_RESP)
            resp_r <= WDATA;
        else if (WR && ADDR == frsc_pkg::ADDR_SUPPLY)
            supply_r <= WDATA;
    end

    // CRC fault flag: any write of one to the reserved bit sets it, set wins over clear
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
            crc_flag_r <= 1'b0;
        else if (WR && ADDR == frsc_pkg::ADDR_RESP && WDATA[frsc_pkg::RSVD_BIT])
            crc_flag_r <= 1'b1;
        else if (clr_sync_r[1])
            crc_flag_r <= 1'b0;
    end

    // Two-stage synchronisers for pin inputs
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            flt_meta_r <= '0;
            flt_r <= '0;
            ot_sync_r <= '0;
            clr_sync_r <= '0;
        end
        else
        begin
            flt_meta_r <= FAULT_IN;
            flt_r <= flt_meta_r;
            ot_sync_r <= {ot_sync_r[0], OVERTEMP_IN};
            clr_sync_r <= {clr_sync_r[0], CRC_CLEAR};
        end
    end

    // Per-fault response codes; fault 1 is the regulator single bit
    always_comb
    begin
        code[0] = fld(resp_r, frsc_pkg::SC_LSB);
        code[1] = resp_r[frsc_pkg::REG_BIT] ? frsc_pkg::RESP_NONE
                                           : frsc_pkg::RESP_LOW;
        code[2] = fld(resp_r, frsc_pkg::OC_LSB);
        code[3] = fld(resp_r, frsc_pkg::PS_LSB);
        code[4] = fld(resp_r, frsc_pkg::GM_LSB);
        code[5] = fld(resp_r, frsc_pkg::LINK_LSB);
        code[6] = fld(supply_r, frsc_pkg::PUV_LSB);
        code[7] = fld(supply_r, frsc_pkg::POV_LSB);
        code[8] = fld(supply_r, frsc_pkg::NUV_LSB);
        code[9] = fld(supply_r, frsc_pkg::NOV_LSB);
        code[10] = fld(supply_r, frsc_pkg::TRIM_LSB);
        code[11] = fld(supply_r, frsc_pkg::CLK_LSB);
    end

    // Combine active faults: low beats high beats hi-z; code 2 only meaningful for gate monitor
    always_comb
    begin
        want_hi = 1'b0;
        want_lo = 1'b0;
        want_hz = 1'b0;
        for (int i = 0; i < 12; i++)
        begin
            if (flt_r[i])
            begin
                case (code[i])
                    frsc_pkg::RESP_LOW: want_lo = 1'b1;
                    frsc_pkg::RESP_HIGH: want_hi = 1'b1;
                    frsc_pkg::RESP_HIZ: want_hz = (i == 4) ? 1'b1 : want_hz;
                    default: want_lo = want_lo;
                endcase
            end
        end
        if (crc_flag_r && fld(supply_r, frsc_pkg::CFGC_LSB) == frsc_pkg::RESP_LOW)
            want_lo = 1'b1;
        else if (crc_flag_r && fld(supply_r, frsc_pkg::CFGC_LSB) == frsc_pkg::RESP_HIGH)
            want_hi = 1'b1;
    end

    // Gate output state registers
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            pl_r <= 1'b0;
            ph_r <= 1'b0;
            hz_r <= 1'b0;
        end
        else
        begin
            pl_r <= want_lo;
            ph_r <= want_hi && !want_lo;
            hz_r <= want_hz && !want_lo && !want_hi;
        end
    end

    // Overtemperature warning gated by enable bit
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
            warn_r <= 1'b0;
        else
            warn_r <= ot_sync_r[1] && resp_r[frsc_pkg::WARN_BIT];
    end

    // Clamp hold length: (code+1) steps of 2 cycles, 80 ns at 25 MHz
    assign clamp_len = 4'((fld(supply_r, frsc_pkg::CLAMP_LSB) + 3'h1)
                          * frsc_pkg::CLAMP_STEP_CYC);

    // Clamp hold timer started when a pull-low response begins
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            clamp_prev_r <= 1'b0;
            clamp_cnt_r <= 4'h0;
            clamp_r <= 1'b0;
        end
        else
        begin
            clamp_prev_r <= want_lo;
            if (want_lo && !clamp_prev_r)
            begin
                clamp_cnt_r <= clamp_len;
                clamp_r <= 1'b1;
            end
            else if (clamp_cnt_r > 4'h1)
                clamp_cnt_r <= clamp_cnt_r - 4'h1;
            else
            begin
                clamp_cnt_r <= 4'h0;
                clamp_r <= 1'b0;
            end
        end
    end

    // Read data, valid in the cycle after the read strobe
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
            rdata_r <= 16'h0000;
        else if (RD)
        begin
            case (ADDR)
                frsc_pkg::ADDR_RESP: rdata_r <= resp_r;
                frsc_pkg::ADDR_SUPPLY: rdata_r <= supply_r;
                frsc_pkg::ADDR_STATUS: rdata_r <= {10'h000, clamp_r, crc_flag_r,
                                                  warn_r, hz_r, ph_r, pl_r};
                default: rdata_r <= 16'h0000;
            endcase
        end
        else
            rdata_r <= 16'h0000;
    end

    assign RDATA = rdata_r;
    assign PULL_HIGH = ph_r;
    assign PULL_LOW = pl_r;
    assign GATE_HIZ = hz_r;
    assign OVERTEMP_WARN = warn_r;
    assign CONFIG_CRC_FAULT_FLAG = crc_flag_r;
    assign CLAMP_ACTIVE = clamp_r;
endmodule
`default_nettype wire

/* File: frsc_bank_asserts.sv */
// Checker for the fault response bank, watching the top module's ports
// Assumes one clock CLK and an asynchronous active-low ARST_N
`timescale 1ns/1ps
`default_nettype none
module frsc_bank_asserts
(
    // Clock and reset
    input wire logic CLK,
    input wire logic ARST_N,
    // Register port
    input wire logic [3:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [15:0] RDATA,
    // Detector inputs
    input wire logic [11:0] FAULT_IN,
    input wire logic OVERTEMP_IN,
    input wire logic CRC_CLEAR,
    // Outputs under watch
    input wire logic PULL_HIGH,
    input wire logic PULL_LOW,
    input wire logic GATE_HIZ,
    input wire logic OVERTEMP_WARN,
    input wire logic CONFIG_CRC_FAULT_FLAG,
    input wire logic CLAMP_ACTIVE
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!ARST_N);
    // Write of one to the reserved bit
    sequence s_rsvd_wr;
        WR && ADDR == frsc_pkg::ADDR_RESP && WDATA[frsc_pkg::RSVD_BIT];
    endsequence
    // Detectors and flag quiet through the synchroniser
    sequence s_quiet;
        (FAULT_IN == 12'h000 && !CONFIG_CRC_FAULT_FLAG)[*4];
    endsequence
    // Clamp pulse just started
    sequence s_clamp_go;
        $rose(CLAMP_ACTIVE);
    endsequence
    AST_CRC_SET: assert property (s_rsvd_wr |=> CONFIG_CRC_FAULT_FLAG)
        else $error("reserved write left flag clear");
    AST_SPARE_NOCRC: assert property (!CONFIG_CRC_FAULT_FLAG &&
        !(WR && ADDR == frsc_pkg::ADDR_RESP && WDATA[frsc_pkg::RSVD_BIT])
        |=> !CONFIG_CRC_FAULT_FLAG)
        else $error("flag set without reserved write");
    AST_CRC_HOLD: assert property (CONFIG_CRC_FAULT_FLAG && !CRC_CLEAR &&
        !$past(CRC_CLEAR) && !$past(CRC_CLEAR, 2) |=> CONFIG_CRC_FAULT_FLAG)
        else $error("flag dropped without clear");
    AST_WARN_QUIET: assert property ((!OVERTEMP_IN)[*4] |-> !OVERTEMP_WARN)
        else $error("warning without overtemp");
    AST_OUT_EXCL: assert property ($onehot0({PULL_LOW, PULL_HIGH, GATE_HIZ}))
        else $error("gate outputs overlap");
    AST_OUT_QUIET: assert property (s_quiet |-> !PULL_LOW && !PULL_HIGH && !GATE_HIZ)
        else $error("gate action without fault");
    AST_CLAMP_MIN: assert property (s_clamp_go |-> CLAMP_ACTIVE[*2])
        else $error("clamp shorter than one step");
    AST_CLAMP_MAX: assert property (s_clamp_go |-> ##[2:8] !CLAMP_ACTIVE)
        else $error("clamp longer than four steps");
endmodule
bind frsc_bank frsc_bank_asserts i_chk
(
    .CLK(CLK), .ARST_N(ARST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .FAULT_IN(FAULT_IN), .OVERTEMP_IN(OVERTEMP_IN), .CRC_CLEAR(CRC_CLEAR),
    .PULL_HIGH(PULL_HIGH), .PULL_LOW(PULL_LOW), .GATE_HIZ(GATE_HIZ),
    .OVERTEMP_WARN(OVERTEMP_WARN), .CONFIG_CRC_FAULT_FLAG(CONFIG_CRC_FAULT_FLAG),
    .CLAMP_ACTIVE(CLAMP_ACTIVE)
);
`default_nettype wire

/* File: tb_top.sv */
// Self-checking bench for the fault response bank
// Assumes the bank alone on a 25 MHz clock, driven at its ports
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin err_total++; \
    $display("BAD %0t got %h want %h", $time, a, e); end end
module tb_top;
    typedef struct packed {logic [3:0] a; logic [15:0] d; logic [11:0] f; logic [2:0] o;} frsc_row_s;
    logic CLK = 1'b0;
    logic ARST_N = 1'b0;
    logic [3:0] ADDR = 4'h0;
    logic [15:0] WDATA = 16'h0000;
    logic WR = 1'b0;
    logic RD = 1'b0;
    logic [11:0] FAULT_IN = 12'h000;
    logic OVERTEMP_IN = 1'b0;
    logic CRC_CLEAR = 1'b0;
    logic [15:0] RDATA;
    logic [15:0] got;
    logic PULL_HIGH, PULL_LOW, GATE_HIZ, OVERTEMP_WARN, CONFIG_CRC_FAULT_FLAG, CLAMP_ACTIVE;
    int err_total = 0;
    int compares = 0;
    // Register value, fault vector, expected {low, high, hiz}; code 2 only for gate monitor
    frsc_row_s rows [12] = '{'{4'h0, 16'hcbcf, 12'h001, 3'h4}, '{4'h0, 16'hdbcf, 12'h001, 3'h2},
        '{4'h0, 16'hf3cf, 12'h002, 3'h4}, '{4'h0, 16'hf9cf, 12'h004, 3'h2},
        '{4'h0, 16'hfb0f, 12'h008, 3'h4}, '{4'h0, 16'hfbcb, 12'h010, 3'h1},
        '{4'h0, 16'hfbcd, 12'h020, 3'h2}, '{4'h1, 16'h7ff3, 12'h040, 3'h2},
        '{4'h1, 16'hfcf3, 12'h200, 3'h4}, '{4'h1, 16'hfff0, 12'h800, 3'h4},
        '{4'h2, 16'hffff, 12'h000, 3'h0}, '{4'hf, 16'h1234, 12'h000, 3'h0}};
    frsc_bank i_dut
    (
        .CLK(CLK), .ARST_N(ARST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .FAULT_IN(FAULT_IN), .OVERTEMP_IN(OVERTEMP_IN), .CRC_CLEAR(CRC_CLEAR),
        .PULL_HIGH(PULL_HIGH), .PULL_LOW(PULL_LOW), .GATE_HIZ(GATE_HIZ),
        .OVERTEMP_WARN(OVERTEMP_WARN), .CONFIG_CRC_FAULT_FLAG(CONFIG_CRC_FAULT_FLAG),
        .CLAMP_ACTIVE(CLAMP_ACTIVE)
    );
    // Clock
    always #20 CLK = ~CLK;
    // One-cycle register write
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge CLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
    endtask
    // Read, data taken in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge CLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        #1;
        d = RDATA;
    endtask
    // Counts and verdict
    task automatic final_report();
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Watchdog
    initial
    begin
        #(40 * 4000);
        err_total++;
        final_report();
    end
    // Row loop, then reset values, warning, spare and reserved bits
    initial
    begin
        repeat (10) @(posedge CLK);
        ARST_N <= 1'b1;
        foreach (rows[i])
        begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, got);
            `CHK(got, (rows[i].a < 4'h2) ? rows[i].d : 16'h0000)
            @(posedge CLK) FAULT_IN <= rows[i].f;
            repeat (4) @(posedge CLK);
            #1 `CHK({PULL_LOW, PULL_HIGH, GATE_HIZ}, rows[i].o)
            @(posedge CLK) FAULT_IN <= 12'h000;
            repeat (8) @(posedge CLK);
            $display("row %0d done", i);
        end
        @(posedge CLK) ARST_N <= 1'b0;
        repeat (2) @(posedge CLK);
        ARST_N <= 1'b1;
        rd(4'h0, got);
        `CHK(got, 16'hc008)
        rd(4'h1, got);
        `CHK(got, 16'h0000)
        @(posedge CLK) OVERTEMP_IN <= 1'b1;
        repeat (4) @(posedge CLK);
        #1 `CHK(OVERTEMP_WARN, 1'b1)
        wr(4'h0, 16'h4038);
        repeat (3) @(posedge CLK);
        #1 `CHK({OVERTEMP_WARN, CONFIG_CRC_FAULT_FLAG}, 2'b00)
        wr(4'h0, 16'hc408);
        #1 `CHK(CONFIG_CRC_FAULT_FLAG, 1'b1)
        @(posedge CLK);
        #1 `CHK(CLAMP_ACTIVE, 1'b1)
        repeat (3) @(posedge CLK);
        #1 `CHK(PULL_LOW, 1'b1)
        @(posedge CLK) CRC_CLEAR <= 1'b1;
        repeat (4) @(posedge CLK);
        CRC_CLEAR <= 1'b0;
        #1 `CHK(CONFIG_CRC_FAULT_FLAG, 1'b0)
        $display("hand tests done");
        final_report();
    end
endmodule
`default_nettype wire
